// *** hw/ecs_delay.sv ***
// module: programmable one-shot delay timer used for access offsets
`timescale 1ns/1ps
`default_nettype none
module ecs_delay #(
    parameter int W = 24 // counter width
) (
    input  wire logic         SYS_CLK,  // block clock
    input  wire logic         SYS_RST,  // sync reset, high
    input  wire logic         start,    // pulse: arm the timer
    input  wire logic [W-1:0] dly,      // delay in cycles
    output logic              fire      // pulse when delay runs out
);
    logic [W-1:0] cnt_r;   // remaining cycles
    logic [W-1:0] cnt_nxt;
    logic         run_r;   // timer armed
    logic         run_nxt;
    logic         fire_r;
    logic         fire_nxt;

    // next state: a new start restarts the count
    always_comb begin
        cnt_nxt  = cnt_r;
        run_nxt  = run_r;
        fire_nxt = 1'b0;
        if (start) begin
            if (dly == '0) begin
                fire_nxt = 1'b1; // zero delay fires at once
                run_nxt  = 1'b0;
            end else begin
                cnt_nxt = dly - W'(1);
                run_nxt = 1'b1;
            end
        end else if (run_r) begin
            if (cnt_r == '0) begin
                fire_nxt = 1'b1;
                run_nxt  = 1'b0;
            end else begin
                cnt_nxt = cnt_r - W'(1);
            end
        end
    end

    // registers only
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            cnt_r  <= '0;
            run_r  <= 1'b0;
            fire_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            run_r  <= run_nxt;
            fire_r <= fire_nxt;
        end
    end

    assign fire = fire_r;
endmodule
`default_nettype wire

// *** hw/ecs_pkg.sv ***
// package: constants, modes and carrier types for the cycle synchronizer
package ecs_pkg;
    // operation modes
    typedef enum logic [0:0] {
        ECS_OP_PLAIN = 1'b0, // ordinary cyclic, no constant period
        ECS_OP_EQUI  = 1'b1  // equidistant_motion_mode
    } ecs_op_t;
    // source of the cycle sync pulse
    typedef enum logic [1:0] {
        ECS_SYNC_HOST  = 2'b00, // sync disabled, host is master
        ECS_SYNC_SLAVE = 2'b01, // pulse from hardware link
        ECS_SYNC_MASTER = 2'b10 // block makes the pulse
    } ecs_sync_t;
    // register offsets
    localparam logic [3:0] ECS_REG_CTRL   = 4'h0;
    localparam logic [3:0] ECS_REG_CYCLE  = 4'h1;
    localparam logic [3:0] ECS_REG_ACCESS = 4'h2;
    localparam logic [3:0] ECS_REG_WINDOW = 4'h3;
    localparam logic [3:0] ECS_REG_STATUS = 4'h4;
    localparam logic [3:0] ECS_REG_COUNT  = 4'h5;
    // control fields
    localparam int ECS_CTRL_OP_BIT    = 0;
    localparam int ECS_CTRL_SYNC_LSB  = 1;
    localparam int ECS_CTRL_CLR_BIT   = 3;
    // status fields
    localparam int ECS_ST_LOCK_BIT    = 0;
    localparam int ECS_ST_LOST_BIT    = 1;
    // reset values, in cycles of SYS_CLK (25 MHz)
    localparam int CLK_MHZ = 25;
    localparam int CYCLE_US_DEF = 1000;
    localparam logic [23:0] ECS_CYCLE_RST  = 24'(CYCLE_US_DEF * CLK_MHZ);
    // access offset reset: 15 percent of the cycle
    localparam int ACCESS_PCT = 15;
    localparam logic [23:0] ECS_ACCESS_RST =
        24'(CYCLE_US_DEF * CLK_MHZ * ACCESS_PCT / 100);
    // capture window: 10 percent of access, capped at 50 us
    localparam int WINDOW_MAX_US = 50;
    localparam logic [23:0] ECS_WINDOW_MAX = 24'(WINDOW_MAX_US * CLK_MHZ);
    localparam logic [23:0] ECS_WINDOW_RST = 24'(ECS_ACCESS_RST / 10);
    // sync pulse length, in SYS_CLK cycles
    localparam logic [7:0] ECS_PULSE_LEN = 8'h04;
    // register bus request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ecs_bus_t;
endpackage

// *** hw/ecs_top.sv ***
// module: equidistant bus cycle synchronizer with register port
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ecs_top
#(
    parameter int W = 24 // timer width
) (
    input  wire logic        SYS_CLK,     // block clock, 25 MHz
    input  wire logic        SYS_RST,     // sync reset, active high
    input  wire logic [3:0]  ADDR,        // register index
    input  wire logic [31:0] WDATA,       // write data
    input  wire logic        WR,          // write strobe
    input  wire logic        RD,          // read strobe
    output logic      [31:0] RDATA,       // read data, cycle after RD
    input  wire logic        HOST_SYNC,   // host sync pulse
    input  wire logic        LINK_SYNC_IN,  // link pulse from master
    input  wire logic        BUS_DISTURB, // bus disturbance seen
    output logic             CYCLE_START, // pulse: bus cycle begins
    output logic             GC_SEND,     // pulse: send global control
    output logic             LINK_SYNC_OUT, // link pulse to slaves
    output logic             HOST_SYNC_OUT  // pulse to host task
);
    import ecs_pkg::*;

    ecs_bus_t bus;
    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // configuration registers
    ecs_op_t     op_r, op_nxt;          // operation mode
    ecs_sync_t   sync_r, sync_nxt;      // sync source
    logic [W-1:0] cycle_r, cycle_nxt;   // cycle period in clocks
    logic [W-1:0] access_r, access_nxt; // access offset in clocks
    logic [W-1:0] window_r, window_nxt; // capture window in clocks
    logic [31:0] rdata_r, rdata_nxt;    // read data register
    // cycle engine state
    logic [W-1:0] phase_r, phase_nxt;   // position in the cycle
    logic        lock_r, lock_nxt;      // locked to external pulse, or running as sync master
    logic        lost_r, lost_nxt;      // sticky loss flag
    logic [15:0] ncyc_r, ncyc_nxt;      // cycle counter
    logic        start_r, start_nxt;    // cycle start pulse
    logic [7:0]  pls_r, pls_nxt;        // sync pulse stretch
    logic        hso_r, hso_nxt;        // host sync out
    logic        ext_fire;              // delayed external pulse
    logic        own_fire;              // own host pulse at zero offset (master)
    logic        mst_fire;              // bus start delayed by offset
    logic        ext_go;                // external reference arrives
    logic        wrap;                  // free-running period end

    // window capped at 50 us whatever software writes
    function automatic logic [W-1:0] clamp_win(input logic [31:0] v);
        if (v[W-1:0] > W'(ECS_WINDOW_MAX))
            return W'(ECS_WINDOW_MAX);
        return v[W-1:0];
    endfunction

    // host pulse delayed by the access offset before a cycle starts
    ecs_delay #(.W(W)) u_host_dly (
        .SYS_CLK (SYS_CLK),
        .SYS_RST (SYS_RST),
        .start   (HOST_SYNC && sync_r == ECS_SYNC_HOST),
        .dly     (access_r),
        .fire    (ext_fire)
    );

    // own pulse for the host at zero offset, taken straight from the cycle start
    assign own_fire = (sync_r == ECS_SYNC_MASTER) && start_r &&
                      (access_r == '0);

    // external reference, by mode; slave mode uses no timing value
    always_comb begin
        case (sync_r)
            ECS_SYNC_HOST:  ext_go = ext_fire;
            ECS_SYNC_SLAVE: ext_go = LINK_SYNC_IN;
            default:        ext_go = 1'b0;
        endcase
    end

    assign wrap = (phase_r >= cycle_r - W'(1));

    // register port next values and reads
    always_comb begin
        op_nxt     = op_r;
        sync_nxt   = sync_r;
        cycle_nxt  = cycle_r;
        access_nxt = access_r;
        window_nxt = window_r;
        rdata_nxt  = '0;
        if (bus.wr) begin
            if (bus.addr == ECS_REG_CTRL) begin
                op_nxt   = ecs_op_t'(bus.wdata[ECS_CTRL_OP_BIT]);
                sync_nxt = ecs_sync_t'(bus.wdata[ECS_CTRL_SYNC_LSB +: 2]);
            end else if (bus.addr == ECS_REG_CYCLE) begin
                cycle_nxt = bus.wdata[W-1:0];
            end else if (bus.addr == ECS_REG_ACCESS) begin
                access_nxt = bus.wdata[W-1:0];
            end else if (bus.addr == ECS_REG_WINDOW) begin
                window_nxt = clamp_win(bus.wdata); // cap
            end
        end
        if (bus.rd) begin
            if (bus.addr == ECS_REG_CTRL) begin
                rdata_nxt[ECS_CTRL_OP_BIT] = op_r;
                rdata_nxt[ECS_CTRL_SYNC_LSB +: 2] = sync_r;
            end else if (bus.addr == ECS_REG_CYCLE) begin
                rdata_nxt[W-1:0] = cycle_r;
            end else if (bus.addr == ECS_REG_ACCESS) begin
                rdata_nxt[W-1:0] = access_r;
            end else if (bus.addr == ECS_REG_WINDOW) begin
                rdata_nxt[W-1:0] = window_r;
            end else if (bus.addr == ECS_REG_STATUS) begin
                rdata_nxt[ECS_ST_LOCK_BIT] = lock_r;
                rdata_nxt[ECS_ST_LOST_BIT] = lost_r;
            end else if (bus.addr == ECS_REG_COUNT) begin
                rdata_nxt[15:0] = ncyc_r;
            end
            // unmapped index reads zero
        end
    end

    // cycle engine
    always_comb begin
        phase_nxt = phase_r + W'(1);
        lock_nxt  = lock_r;
        lost_nxt  = lost_r;
        // clear applied first, so any set later in this pass wins
        if (bus.wr && bus.addr == ECS_REG_CTRL && bus.wdata[ECS_CTRL_CLR_BIT])
            lost_nxt = 1'b0;
        ncyc_nxt  = ncyc_r;
        start_nxt = 1'b0;
        if (op_r != ECS_OP_EQUI) begin
            // plain mode: no constant cycle, nothing started here
            phase_nxt = '0;
            lock_nxt  = 1'b0;
        end else if (sync_r == ECS_SYNC_MASTER) begin
            // free-running constant period
            lock_nxt = 1'b1;
            if (wrap) begin
                phase_nxt = '0;
                start_nxt = 1'b1;
            end
        end else if (ext_go) begin
            // reference outside window around expected start flags a loss, lock is kept
            if (!(wrap || phase_r <= window_r ||
                  phase_r + window_r >= cycle_r - W'(1)) && lock_r)
                lost_nxt = 1'b1;
            lock_nxt  = 1'b1;
            phase_nxt = '0;
            start_nxt = 1'b1;
        end else if (lock_r && phase_r >= cycle_r + window_r) begin
            lock_nxt  = 1'b0; // reference missing
            lost_nxt  = 1'b1;
            phase_nxt = '0;
        end else if (!lock_r) begin
            phase_nxt = '0;
        end
        if (start_nxt)
            ncyc_nxt = ncyc_r + 16'h0001;
        if (op_r == ECS_OP_EQUI && BUS_DISTURB && lock_r)
            lost_nxt = 1'b1;
    end

    // sync master outputs: link pulse and delayed host pulse
    always_comb begin
        pls_nxt = (pls_r != '0) ? pls_r - 8'h01 : '0;
        hso_nxt = 1'b0;
        if (op_r == ECS_OP_EQUI && sync_r == ECS_SYNC_MASTER) begin
            if (start_r)
                pls_nxt = ECS_PULSE_LEN;
            if (own_fire || mst_fire)
                hso_nxt = 1'b1;
        end else begin
            pls_nxt = '0;
        end
    end

    // bus cycle start delayed by the offset, host pulse in master mode
    ecs_delay #(.W(W)) u_mst_dly (
        .SYS_CLK (SYS_CLK),
        .SYS_RST (SYS_RST),
        .start   (start_r && sync_r == ECS_SYNC_MASTER && access_r != '0),
        .dly     (access_r - W'(1)),
        .fire    (mst_fire)
    );

    // all registers but the outputs
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            op_r     <= ECS_OP_PLAIN;
            sync_r   <= ECS_SYNC_HOST;
            cycle_r  <= ECS_CYCLE_RST[W-1:0];
            access_r <= ECS_ACCESS_RST[W-1:0];
            window_r <= ECS_WINDOW_RST[W-1:0];
            rdata_r  <= '0;
            phase_r  <= '0;
            lock_r   <= 1'b0;
            lost_r   <= 1'b0;
            ncyc_r   <= '0;
            start_r  <= 1'b0;
            pls_r    <= '0;
            hso_r    <= 1'b0;
        end else begin
            op_r     <= op_nxt;
            sync_r   <= sync_nxt;
            cycle_r  <= cycle_nxt;
            access_r <= access_nxt;
            window_r <= window_nxt;
            rdata_r  <= rdata_nxt;
            phase_r  <= phase_nxt;
            lock_r   <= lock_nxt;
            lost_r   <= lost_nxt;
            ncyc_r   <= ncyc_nxt;
            start_r  <= start_nxt;
            pls_r    <= pls_nxt;
            hso_r    <= hso_nxt;
        end
    end

    // outputs, all from flops
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            CYCLE_START   <= 1'b0;
            GC_SEND       <= 1'b0;
            LINK_SYNC_OUT <= 1'b0;
            HOST_SYNC_OUT <= 1'b0;
        end else begin
            CYCLE_START   <= start_r;
            GC_SEND       <= start_r; // broadcast at cycle start
            LINK_SYNC_OUT <= (pls_r != '0);
            HOST_SYNC_OUT <= hso_r;
        end
    end
    assign RDATA = rdata_r;

    // assertions
    property p_gc_start;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        start_r |=> (GC_SEND && CYCLE_START);
    endproperty
    a_gc_start: assert property (p_gc_start)
        else $error("global control not sent at cycle start");
    property p_plain_idle;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (op_r == ECS_OP_PLAIN && $past(op_r) == ECS_OP_PLAIN) |-> !start_r;
    endproperty
    a_plain_idle: assert property (p_plain_idle)
        else $error("cycle started outside equidistant mode");
    property p_slave_follow;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (op_r == ECS_OP_EQUI && sync_r == ECS_SYNC_SLAVE && LINK_SYNC_IN)
        |=> start_r ##1 CYCLE_START;
    endproperty
    a_slave_follow: assert property (p_slave_follow)
        else $error("slave did not follow link pulse");
    property p_master_link;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (op_r == ECS_OP_EQUI && sync_r == ECS_SYNC_MASTER && start_r &&
         $stable(sync_r)) |-> ##2 LINK_SYNC_OUT;
    endproperty
    a_master_link: assert property (p_master_link)
        else $error("master link pulse missing");
    property p_win_cap;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        window_r <= W'(ECS_WINDOW_MAX);
    endproperty
    a_win_cap: assert property (p_win_cap)
        else $error("capture window above cap");
    property p_lost_sticky;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (lost_r && !(bus.wr && bus.addr == ECS_REG_CTRL)) |=> lost_r;
    endproperty
    a_lost_sticky: assert property (p_lost_sticky)
        else $error("loss flag dropped without clear");

    property p_disturb;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (op_r == ECS_OP_EQUI && BUS_DISTURB && lock_r) |=> lost_r;
    endproperty
    a_disturb: assert property (p_disturb)
        else $error("disturbance not flagged");

    property p_host_zero;
        @(posedge SYS_CLK) disable iff (SYS_RST)
        (op_r == ECS_OP_EQUI && sync_r == ECS_SYNC_HOST && HOST_SYNC &&
         access_r == '0 && $stable(sync_r)) |-> ##2 start_r;
    endproperty
    a_host_zero: assert property (p_host_zero)
        else $error("host pulse did not start cycle");
endmodule
`default_nettype wire

// *** test/ecs_sync_source.sv ***
// model of the host task and of a sync-master adapter feeding the block
`timescale 1ns/1ps
`default_nettype none
module ecs_sync_source (
    input  wire logic        clk,       // bench clock
    input  wire logic        rst,       // sync reset, high
    input  wire logic        host_en,   // host task runs its cycle
    input  wire logic        link_en,   // partner adapter is sync master
    input  wire logic [15:0] period,    // reference period in clocks
    output logic             host_sync, // host reference pulse
    output logic             link_sync  // hardware link pulse
);
    logic [15:0] cnt_r;   // clocks since last reference
    logic [15:0] cnt_nxt; // next count
    logic        hit;     // period boundary reached
    // zero jitter here, so any sane offset covers it
    always_comb begin
        hit = (cnt_r == period - 16'h0001);
        cnt_nxt = (hit || !(host_en || link_en)) ? 16'h0000 : cnt_r + 16'h0001;
    end
    // one-clock pulses; host drives its own line
    // link line only when the partner adapter is master
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r     <= 16'h0000;
            host_sync <= 1'b0;
            link_sync <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            host_sync <= hit && host_en;
            link_sync <= hit && link_en;
        end
    end
endmodule
`default_nettype wire

// *** test/ecs_top_test.sv ***
// self-checking bench for the cycle synchronizer
`timescale 1ns/1ps
`default_nettype none
module ecs_top_test;
    import ecs_pkg::*;
    logic        SYS_CLK, SYS_RST, WR, RD, BUS_DISTURB; // bench drives
    logic [3:0]  ADDR;              // register index
    logic [31:0] WDATA, RDATA, rd_v; // bus data and last read
    logic        CYCLE_START, GC_SEND, LINK_SYNC_OUT, HOST_SYNC_OUT;
    logic        host_sync, link_sync, host_en, link_en; // partner lines
    logic [31:0] cyc, last_ref, last_cs, cs_period, cs_delta; // timing
    logic [31:0] cs_count, lo_delta, lo_run, lo_len, ho_delta, gc_bad;
    int          bad_count, checks_done; // verdict counters

    ecs_top DUT (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .HOST_SYNC(host_sync), .LINK_SYNC_IN(link_sync),
        .BUS_DISTURB(BUS_DISTURB), .CYCLE_START(CYCLE_START),
        .GC_SEND(GC_SEND), .LINK_SYNC_OUT(LINK_SYNC_OUT),
        .HOST_SYNC_OUT(HOST_SYNC_OUT));
    ecs_sync_source src (.clk(SYS_CLK), .rst(SYS_RST), .host_en(host_en),
        .link_en(link_en), .period(16'h0064), .host_sync(host_sync),
        .link_sync(link_sync));

    // 25 MHz clock
    initial begin
        SYS_CLK = 1'b0;
        forever #20 SYS_CLK = ~SYS_CLK;
    end
    // timing monitor on the falling edge, where outputs are settled
    always @(negedge SYS_CLK) begin
        cyc = cyc + 1;
        if (host_sync || link_sync) last_ref = cyc;
        if (GC_SEND !== CYCLE_START) gc_bad = gc_bad + 1;
        if (CYCLE_START) begin
            cs_period = cyc - last_cs;
            cs_delta  = cyc - last_ref;
            last_cs   = cyc;
            cs_count  = cs_count + 1;
        end
        if (LINK_SYNC_OUT && lo_run == 0) lo_delta = cyc - last_cs;
        if (LINK_SYNC_OUT) lo_run = lo_run + 1;
        else if (lo_run != 0) begin
            lo_len = lo_run;
            lo_run = 0;
        end
        if (HOST_SYNC_OUT) ho_delta = cyc - last_cs;
    end
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge SYS_CLK);
        WR    <= 1'b0;
    endtask
    // read strobe, data taken in the following cycle only
    task automatic rd_reg(input logic [3:0] a);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge SYS_CLK);
        RD   <= 1'b0;
        @(negedge SYS_CLK);
        rd_v = RDATA;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask
    // verdict and end of run
    task automatic summarize();
        if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // watchdog, a few times the expected run length
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        bad_count++;
        summarize();
    end

    initial begin
        {SYS_RST, WR, RD, BUS_DISTURB, host_en, link_en} = 6'b100000;
        ADDR = 4'h0;
        WDATA = 32'h0;
        {cyc, last_ref, last_cs, cs_period, cs_delta} = '0;
        {cs_count, lo_delta, lo_run, lo_len, ho_delta, gc_bad} = '0;
        bad_count = 0;
        checks_done = 0;
        wait_clk(12);
        SYS_RST <= 1'b0;
        // reset values, unmapped index reads zero
        rd_reg(ECS_REG_CYCLE);  check(rd_v, 32'h000061A8);
        rd_reg(ECS_REG_ACCESS); check(rd_v, 32'h00000EA6);
        rd_reg(ECS_REG_WINDOW); check(rd_v, 32'h00000177);
        rd_reg(ECS_REG_STATUS); check(rd_v, 32'h00000000);
        rd_reg(4'hF);           check(rd_v, 32'h00000000);
        // oversized window is capped at 50 us
        wr_reg(ECS_REG_WINDOW, 32'h000007D0);
        rd_reg(ECS_REG_WINDOW); check(rd_v, 32'h000004E2);
        // short cycle for the run: offset 15 percent, window near 10
        wr_reg(ECS_REG_CYCLE, 32'h00000064);
        wr_reg(ECS_REG_ACCESS, 32'h0000000F);
        wr_reg(ECS_REG_WINDOW, 32'h00000002);
        // plain mode gives no cycles at all
        wait_clk(300);
        check(cs_count, 32'h0);
        // block is sync master
        wr_reg(ECS_REG_CTRL, 32'h00000005);
        wait_clk(350);
        check(cs_period, 32'd100);
        check(gc_bad, 32'h0);
        check(lo_delta, 32'd1);
        check(lo_len, 32'd4);
        check(32'(ho_delta inside {32'd15, 32'd16}), 32'h1);
        // partner adapter drives the link, no timing needed
        wr_reg(ECS_REG_CTRL, 32'h00000003);
        link_en <= 1'b1;
        wait_clk(350);
        check(cs_delta, 32'd2);
        check(cs_period, 32'd100);
        // host is sync master, cycle follows by the offset
        link_en <= 1'b0;
        host_en <= 1'b1;
        wr_reg(ECS_REG_CTRL, 32'h00000001);
        wait_clk(400);
        check(cs_delta, 32'd18);
        check(cs_period, 32'd100);
        wr_reg(ECS_REG_CTRL, 32'h00000009);
        wait_clk(200);
        rd_reg(ECS_REG_STATUS); check(rd_v, 32'h00000001);
        // a disturbance flags a loss while lock stays, the flag sticks until cleared
        @(posedge SYS_CLK);
        BUS_DISTURB <= 1'b1;
        @(posedge SYS_CLK);
        BUS_DISTURB <= 1'b0;
        rd_reg(ECS_REG_STATUS); check(rd_v[1], 1'b1);
        wait_clk(200);
        rd_reg(ECS_REG_STATUS); check(rd_v[1], 1'b1);
        wr_reg(ECS_REG_CTRL, 32'h00000009);
        rd_reg(ECS_REG_STATUS); check(rd_v, 32'h00000001);
        // zero offset: the host pulse starts the cycle right away
        wr_reg(ECS_REG_ACCESS, 32'h00000000);
        wait_clk(250);
        check(cs_delta, 32'd3);
        // the phase jump above counts as a loss; clear it again
        wr_reg(ECS_REG_CTRL, 32'h00000009);
        rd_reg(ECS_REG_STATUS); check(rd_v, 32'h00000001);
        // host stops: missing reference is a loss of sync
        host_en <= 1'b0;
        wait_clk(250);
        rd_reg(ECS_REG_STATUS); check(rd_v[1], 1'b1);
        // no cycles run now, so the counter must match the monitor
        rd_reg(ECS_REG_COUNT);  check(rd_v, cs_count);
        // master with zero offset: host pulse one behind cycle start
        wr_reg(ECS_REG_CTRL, 32'h00000005);
        rd_reg(ECS_REG_CTRL);   check(rd_v, 32'h00000005);
        wait_clk(250);
        check(ho_delta, 32'd1);
        summarize();
    end
endmodule
`default_nettype wire
